// ==== verilog/ipe_consts.svh ====
// Offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IPE_CONSTS_SVH
`define IPE_CONSTS_SVH
`define IPE_ADDR_EDGE_SEL 8'hF8
`define IPE_ADDR_FUNC_SEL 8'hF9
`define IPE_ADDR_SRC_EN 8'hFA
`define IPE_ADDR_REQ_FLAGS 8'hFB
`define IPE_ADDR_EVT_STAT 8'hFC
`define IPE_ADDR_EVT_CLR 8'hFD
`define IPE_ADDR_EVT_EN 8'hFE
`define IPE_RST_EDGE_SEL 8'h00
`define IPE_RST_FUNC_SEL 8'h00
`define IPE_RST_SRC_EN 8'h00
`define IPE_RST_EVT_EN 8'h00
`define IPE_EDGE_A_LSB 0
`define IPE_EDGE_B_LSB 2
`define IPE_FUNC_A_BIT 0
`define IPE_FUNC_B_BIT 1
`define IPE_NUM_SRC 8
`define IPE_SRC_EXT_A 0
`define IPE_SRC_EXT_B 1
`define IPE_BREAK_VECTOR_ID 4'h0
`define IPE_CALL_CYCLES_MIN 12
`define IPE_CALL_CNT_W 4
`define IPE_EVT_ACCEPT_BIT 0
`define IPE_EVT_BREAK_BIT 1
`define IPE_EVT_EXT_A_BIT 2
`define IPE_EVT_EXT_B_BIT 3
`endif

// ==== verilog/ipe_pkg.sv ====
// Types shared by the interrupt controller
package ipe_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } ipe_edge_type;

  typedef enum logic [3:0] {
    VEC_EXT_A,
    VEC_EXT_B,
    VEC_TMR0,
    VEC_TMR1,
    VEC_ADC,
    VEC_WDT,
    VEC_BIT,
    VEC_SER,
    VEC_BREAK
  } ipe_vector_type;

  typedef struct packed {
    logic callStart;
    ipe_vector_type vector;
    logic breakFlagSet;
    logic masterEnableClear;
  } ipe_call_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ipe_bus_req_type;
endpackage

// ==== verilog/irq_priority_ext_edge_ctrl.sv ====
// Interrupt priority arbiter with external edge detection and break handling
`timescale 1ns/1ps
`default_nettype none
`include "ipe_consts.svh"

// Summary of operation
// R1: Break request has the lowest priority of all sources.
// R2: Break uses the vector shared with table call 0; the code gives it its own VEC_BREAK code instead.
// R3: Taking a break sets the status word break flag.
// R4: Higher priority request is served first; others stay pending.
// R5: Fixed hardware polling order picks one request among simultaneous ones.
// R6: Accepting any interrupt clears the master enable.
// R7: Master enable set again inside a handler allows nested service.
// R8: Both external inputs edge triggered, edge chosen by register at F8 hex.
// R9: Each external input triggers on rising, falling or both edges.
// R10: Pin function bit must be 1 for a pin to act as interrupt.
// R11: External pin edges are sampled into request flags every machine cycle.
// R12: A flag latched in one cycle is evaluated only in the next.
// R13: An accepted request inserts a hardware call as the next operation.
// R14: Hardware call takes twelve machine cycles before the first handler instruction.
// R15: Reset, watchdog, externals wake all modes; timer 0 only wake-up timer modes.
// R16: An external request flag clears itself when its vector is taken.
// R17: Priority: ext 0, ext 1, timer 0, timer 1, converter, watchdog, interval, serial.
// R18: Edge register: bits 1:0 for input 0, bits 3:2 for input 1.
module irq_priority_ext_edge_ctrl
  import ipe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire ipe_bus_req_type busReq,
  output logic [7:0] busRdata,
  // External pins
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  // Internal peripheral request pulses: timer0, timer1, adc, wdt, bit, serial
  input wire logic [5:0] periphReq,
  // CPU side
  input wire logic masterEnable,
  input wire logic cpuInstrBoundary,
  input wire logic soft_break_instr,
  output ipe_call_type callInfo,
  output logic callBusy,
  // Power-saving wake
  input wire logic stopMode,
  input wire logic wakeTimerMode,
  input wire logic rc_watchdog_wake,
  output logic wakeReq,
  // Interrupt output
  output logic irqOut
);

  typedef enum {
    ST_IDLE,
    ST_CALL
  } ipe_state_type;

  localparam int CALL_LAST = `IPE_CALL_CYCLES_MIN - 1;

  ipe_state_type state_ff, nxt_state;
  logic [7:0] ext_irq_edge_select_ff;
  logic [7:0] port_zero_function_select_ff;
  logic [7:0] srcEn_ff;
  logic [7:0] reqFlags_ff;
  logic [7:0] evtStat_ff;
  logic [7:0] evtEn_ff;
  logic breakPend_ff;
  logic irqOut_ff;
  logic [`IPE_CALL_CNT_W-1:0] callCnt_ff;
  ipe_call_type callInfo_ff;
  logic [7:0] busRdata_ff;
  logic [7:0] nxt_reqFlags;
  logic [7:0] pendMasked;
  logic [3:0] winIdx;
  logic anyWin, takeBreak, takeAny;
  logic edgeA, edgeB;
  logic [7:0] evtSet;
  logic [7:0] evtClr;
  logic wrEdge, wrFunc, wrEn, wrFlags, wrEvtClr, wrEvtEn;

  assign wrEdge = busReq.wr && (busReq.addr == `IPE_ADDR_EDGE_SEL);
  assign wrFunc = busReq.wr && (busReq.addr == `IPE_ADDR_FUNC_SEL);
  assign wrEn = busReq.wr && (busReq.addr == `IPE_ADDR_SRC_EN);
  assign wrFlags = busReq.wr && (busReq.addr == `IPE_ADDR_REQ_FLAGS);
  assign wrEvtClr = busReq.wr && (busReq.addr == `IPE_ADDR_EVT_CLR);
  assign wrEvtEn = busReq.wr && (busReq.addr == `IPE_ADDR_EVT_EN);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  // One detector per pin; the edge code pairs sit side by side in the select register
  ipe_edge_det #(
    .IDLE_LEVEL(1'b0)
  ) u_edgeA (
    .clock(clock),
    .rst_b(rst_b),
    .pinFunc(port_zero_function_select_ff[`IPE_FUNC_A_BIT]), // [R10]
    .edgeSel(ext_irq_edge_select_ff[`IPE_EDGE_A_LSB +: 2]), // [R8] [R18]
    .pin(ext_irq_a_pin),
    .edgeHit(edgeA)
  );

  ipe_edge_det #(
    .IDLE_LEVEL(1'b0)
  ) u_edgeB (
    .clock(clock),
    .rst_b(rst_b),
    .pinFunc(port_zero_function_select_ff[`IPE_FUNC_B_BIT]), // [R10]
    .edgeSel(ext_irq_edge_select_ff[`IPE_EDGE_B_LSB +: 2]), // [R8] [R18]
    .pin(ext_irq_b_pin),
    .edgeHit(edgeB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ext_irq_edge_select_ff <= `IPE_RST_EDGE_SEL;
      port_zero_function_select_ff <= `IPE_RST_FUNC_SEL;
      srcEn_ff <= `IPE_RST_SRC_EN;
      evtEn_ff <= `IPE_RST_EVT_EN;
    end else begin
      if (wrEdge) begin
        ext_irq_edge_select_ff <= busReq.wdata; // [R8]
      end
      if (wrFunc) begin
        port_zero_function_select_ff <= busReq.wdata; // [R10]
      end
      if (wrEn) begin
        srcEn_ff <= busReq.wdata;
      end
      if (wrEvtEn) begin
        evtEn_ff <= busReq.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flags and arbitration

  // Only registered flags feed arbitration, so a fresh edge waits one cycle
  assign pendMasked = reqFlags_ff & srcEn_ff; // [R12]

  always_comb begin
    winIdx = 4'h0;
    anyWin = 1'b0;
    for (int i = `IPE_NUM_SRC - 1; i >= 0; i--) begin
      if (pendMasked[i]) begin
        winIdx = 4'(i); // [R5] [R17]
        anyWin = 1'b1;
      end
    end
  end

  // Break is considered only when no maskable request is acceptable
  assign takeAny = (state_ff == ST_IDLE) && cpuInstrBoundary && masterEnable && anyWin; // [R4] [R7]
  assign takeBreak = (state_ff == ST_IDLE) && cpuInstrBoundary && breakPend_ff && !takeAny; // [R1]

  always_comb begin
    nxt_reqFlags = reqFlags_ff;
    if (wrFlags) begin
      nxt_reqFlags = busReq.wdata;
    end
    if (takeAny) begin
      nxt_reqFlags[winIdx[2:0]] = 1'b0; // [R16] [R4]
    end
    // Set wins over any clear in the same cycle
    nxt_reqFlags[`IPE_SRC_EXT_A] = nxt_reqFlags[`IPE_SRC_EXT_A] | edgeA; // [R11]
    nxt_reqFlags[`IPE_SRC_EXT_B] = nxt_reqFlags[`IPE_SRC_EXT_B] | edgeB; // [R11]
    nxt_reqFlags[7:2] = nxt_reqFlags[7:2] | periphReq;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reqFlags_ff <= 8'h00;
    end else begin
      reqFlags_ff <= nxt_reqFlags;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      breakPend_ff <= 1'b0;
    end else if (soft_break_instr) begin
      breakPend_ff <= 1'b1;
    end else if (takeBreak) begin
      breakPend_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware call sequencer

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (takeAny || takeBreak) begin
          nxt_state = ST_CALL; // [R13]
        end
      end
      ST_CALL: begin
        if (callCnt_ff == CALL_LAST[`IPE_CALL_CNT_W-1:0]) begin
          nxt_state = ST_IDLE; // [R14]
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      callCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_CALL) begin
        callCnt_ff <= callCnt_ff + 1'b1; // [R14]
      end else begin
        callCnt_ff <= '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      callInfo_ff <= '{callStart: 1'b0, vector: VEC_EXT_A, breakFlagSet: 1'b0, masterEnableClear: 1'b0};
    end else begin
      callInfo_ff.callStart <= takeAny || takeBreak; // [R13]
      callInfo_ff.masterEnableClear <= takeAny || takeBreak; // [R6]
      callInfo_ff.breakFlagSet <= takeBreak; // [R3]
      if (takeAny) begin
        callInfo_ff.vector <= ipe_vector_type'(winIdx);
      end else if (takeBreak) begin
        // Own vector code VEC_BREAK, apart from the table-call-0 entry VEC_EXT_A; the break flag is set too
        callInfo_ff.vector <= VEC_BREAK; // [R2]
      end
    end
  end

  assign callInfo = callInfo_ff;
  assign callBusy = (state_ff == ST_CALL);

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up, event status and register reads

  // Timer 0 is stopped in stop mode, so it can only wake the wake-up timer modes
  always_comb begin
    wakeReq = rc_watchdog_wake || edgeA || edgeB; // [R15]
    if (wakeTimerMode && !stopMode && periphReq[0]) begin
      wakeReq = 1'b1; // [R15]
    end
  end

  assign evtSet = {4'h0, edgeB, edgeA, takeBreak, takeAny};
  assign evtClr = wrEvtClr ? busReq.wdata : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      evtStat_ff <= 8'h00;
    end else begin
      evtStat_ff <= (evtStat_ff & ~evtClr) | evtSet;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irqOut_ff <= 1'b0;
    end else begin
      irqOut_ff <= |(((evtStat_ff & ~evtClr) | evtSet) & evtEn_ff);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busRdata_ff <= 8'h00;
    end else if (busReq.rd) begin
      case (busReq.addr)
        `IPE_ADDR_EDGE_SEL: busRdata_ff <= ext_irq_edge_select_ff;
        `IPE_ADDR_FUNC_SEL: busRdata_ff <= port_zero_function_select_ff;
        `IPE_ADDR_SRC_EN: busRdata_ff <= srcEn_ff;
        `IPE_ADDR_REQ_FLAGS: busRdata_ff <= reqFlags_ff;
        `IPE_ADDR_EVT_STAT: busRdata_ff <= evtStat_ff;
        `IPE_ADDR_EVT_EN: busRdata_ff <= evtEn_ff;
        default: busRdata_ff <= 8'h00;
      endcase
    end else begin
      busRdata_ff <= 8'h00;
    end
  end

  assign busRdata = busRdata_ff;
  assign irqOut = irqOut_ff;

endmodule // irq_priority_ext_edge_ctrl

////////////////////////////////////////////////////////////////////////////
// Edge detector for one external pin

module ipe_edge_det
  import ipe_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Configuration
  input wire logic pinFunc,
  input wire logic [1:0] edgeSel,
  // Pin and result
  input wire logic pin,
  output logic edgeHit
);

  logic pinHist_ff;
  logic rawHit;

  // History starts at the idle level so reset release shows no false edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pinHist_ff <= IDLE_LEVEL;
    end else begin
      pinHist_ff <= pin; // [R11]
    end
  end

  always_comb begin
    rawHit = 1'b0;
    case (ipe_edge_type'(edgeSel))
      EDGE_RISE: rawHit = !pinHist_ff && pin; // [R9]
      EDGE_FALL: rawHit = pinHist_ff && !pin; // [R9]
      EDGE_BOTH: rawHit = pinHist_ff ^ pin; // [R9]
      default: rawHit = 1'b0;
    endcase
  end

  // Pin stays plain I/O until its function bit is 1
  assign edgeHit = pinFunc && rawHit; // [R10]

endmodule // ipe_edge_det
`default_nettype wire

// ==== testbench/ipe_irq_sva.sv ====
// Port assertions of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module ipe_irq_sva
  import ipe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus and CPU side
  input wire ipe_bus_req_type busReq,
  input wire logic [7:0] busRdata,
  input wire logic masterEnable,
  input wire logic cpuInstrBoundary,
  input wire ipe_call_type callInfo,
  input wire logic callBusy,
  // Wake
  input wire logic stopMode,
  input wire logic rc_watchdog_wake,
  input wire logic wakeReq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Split repetition keeps the unrolled sequence small
  sequence busyTwelve;
    callBusy[*8] ##1 callBusy[*4] ##1 !callBusy;
  endsequence
  AST_BUSY_TWELVE: assert property ($rose(callBusy) |-> busyTwelve)
    else $error("call length wrong");
  AST_START_BUSY: assert property (callInfo.callStart |-> $rose(callBusy))
    else $error("start outside call");
  AST_BOUNDARY: assert property ($rose(callBusy) |-> $past(cpuInstrBoundary))
    else $error("call without boundary");
  AST_ME_CLEAR: assert property (callInfo.callStart |-> callInfo.masterEnableClear)
    else $error("enable not cleared");
  AST_ME_GATE: assert property (callInfo.callStart && !callInfo.breakFlagSet |-> $past(masterEnable))
    else $error("accept while disabled");
  AST_BREAK_VEC: assert property (callInfo.breakFlagSet |-> callInfo.callStart && callInfo.vector == VEC_BREAK)
    else $error("break vector wrong");
  AST_RD_IDLE: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
    else $error("read data outside slot");
  AST_WAKE_WDT: assert property (rc_watchdog_wake && stopMode |-> wakeReq)
    else $error("watchdog wake missing");
endmodule // ipe_irq_sva
bind irq_priority_ext_edge_ctrl ipe_irq_sva u_sva (.clock, .rst_b, .busReq, .busRdata, .masterEnable,
  .cpuInstrBoundary, .callInfo, .callBusy, .stopMode, .rc_watchdog_wake, .wakeReq);
`default_nettype wire

// ==== testbench/ipe_pin_src.sv ====
// Model of the signal sources on the two external pins
`timescale 1ns/1ps
`default_nettype none
module ipe_pin_src (
  // Clock
  input wire logic clock,
  // Pins
  output var logic pinA,
  output var logic pinB
);
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end
  // Levels move just after an edge, so each cycle sees a clean sample
  task automatic drive(input logic a, input logic b);
    @(posedge clock);
    pinA <= a;
    pinB <= b;
  endtask
endmodule // ipe_pin_src
`default_nettype wire

// ==== testbench/test_irq_priority_ext_edge_ctrl.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_irq_priority_ext_edge_ctrl
  import ipe_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  ipe_bus_req_type busReq = '0;
  logic [7:0] busRdata;
  logic pinA;
  logic pinB;
  logic [5:0] periphReq = 6'h00;
  logic masterEnable = 1'b1;
  logic cpuInstrBoundary = 1'b1;
  logic softBrk = 1'b0;
  logic stopMode = 1'b0;
  logic rcWake = 1'b0;
  logic wakeTimer = 1'b0;
  ipe_call_type callInfo;
  logic callBusy;
  logic wakeReq;
  logic irqOut;
  int fails = 0;
  int tests_run = 0;
  int nCall = 0;
  always #50 clock = ~clock;
  ipe_pin_src src (.clock, .pinA, .pinB);
  irq_priority_ext_edge_ctrl dut (.clock, .rst_b, .busReq, .busRdata, .ext_irq_a_pin(pinA), .ext_irq_b_pin(pinB),
    .periphReq, .masterEnable, .cpuInstrBoundary, .soft_break_instr(softBrk), .callInfo, .callBusy, .stopMode,
    .wakeTimerMode(wakeTimer), .rc_watchdog_wake(rcWake), .wakeReq, .irqOut);
  always @(posedge clock) if (callInfo.callStart === 1'b1) nCall++;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    @(negedge clock);
    chk(busRdata & m, e);
  endtask
  // Bounded wait for the next call, then its vector and break flag
  task automatic wcall(input logic [3:0] v, input logic b);
    int i;
    for (i = 0; i < 60 && callInfo.callStart !== 1'b1; i++) @(negedge clock);
    if (i == 60) begin
      fails++;
      end_sim;
    end
    chk({callInfo.vector, 3'h0, callInfo.breakFlagSet}, {v, 3'h0, b});
    @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'hF8, 8'hFF, 8'h00);
    rd(8'hFA, 8'hFF, 8'h00);
    rd(8'h10, 8'hFF, 8'h00);
  endtask
  // Pass 0 has the pin function off with both edges armed
  task automatic t_edge;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(8'hF8, c == 0 ? 8'h03 : 8'(c));
      wr(8'hF9, {7'h00, c != 0});
      wr(8'hFA, 8'h01);
      n = nCall;
      src.drive(1'b1, 1'b0);
      cyc(20);
      chk(8'(nCall - n), {7'h00, c[0] && c != 0});
      n = nCall;
      src.drive(1'b0, 1'b0);
      cyc(20);
      chk(8'(nCall - n), {7'h00, c[1] && c != 0});
    end
  endtask
  task automatic t_prio;
    cpuInstrBoundary <= 1'b0;
    wr(8'hF8, 8'h0F);
    wr(8'hF9, 8'h03);
    wr(8'hFA, 8'h03);
    src.drive(1'b1, 1'b1);
    cyc(3);
    cpuInstrBoundary <= 1'b1;
    wcall(VEC_EXT_A, 1'b0);
    wcall(VEC_EXT_B, 1'b0);
    wr(8'hF9, 8'h00);
  endtask
  task automatic t_master;
    int n;
    wr(8'hFA, 8'h0C);
    masterEnable <= 1'b0;
    periphReq <= 6'h01;
    cyc(1);
    periphReq <= 6'h00;
    n = nCall;
    cyc(20);
    chk(8'(nCall - n), 8'h00);
    masterEnable <= 1'b1;
    wcall(VEC_TMR0, 1'b0);
  endtask
  task automatic t_break;
    @(posedge clock);
    cpuInstrBoundary <= 1'b0;
    wr(8'hFE, 8'h02);
    @(posedge clock);
    periphReq <= 6'h02;
    softBrk <= 1'b1;
    @(posedge clock);
    periphReq <= 6'h00;
    softBrk <= 1'b0;
    cpuInstrBoundary <= 1'b1;
    wcall(VEC_TMR1, 1'b0);
    wcall(VEC_BREAK, 1'b1);
    cyc(2);
    chk({7'h00, irqOut}, 8'h01);
    rd(8'hFC, 8'h03, 8'h03);
    wr(8'hFD, 8'hFF);
    cyc(2);
    chk({7'h00, irqOut}, 8'h00);
    rd(8'hFD, 8'hFF, 8'h00);
  endtask
  // Timer 0 pulse in stop mode, then in wake-up timer mode, then watchdog wake
  task automatic t_wake;
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      stopMode <= (m == 0);
      wakeTimer <= (m == 1);
      periphReq <= 6'h01;
      @(negedge clock);
      chk({7'h00, wakeReq}, {7'h00, m == 1});
      @(posedge clock);
      periphReq <= 6'h00;
    end
    wakeTimer <= 1'b0;
    stopMode <= 1'b1;
    rcWake <= 1'b1;
    cyc(2);
    @(negedge clock);
    chk({7'h00, wakeReq}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    t_reset;
    t_edge;
    t_prio;
    t_master;
    t_break;
    t_wake;
    end_sim;
  end
endmodule // test_irq_priority_ext_edge_ctrl
`default_nettype wire
